// [rtl/tops_pkg.sv]
// Purpose: Constants for the one-shot pulse timer.
// Assumes: One-cycle read latency.
// Notes:   Offsets are word indices on the plain register port.
package tops_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_PWR      = 4'h0;  // Unit power enable
    localparam logic [3:0] OFS_PRESC    = 4'h1;  // Clock prescaler select
    localparam logic [3:0] OFS_NFEN     = 4'h2;  // Input noise filter enable
    localparam logic [3:0] OFS_MMODE    = 4'h3;  // Master mode
    localparam logic [3:0] OFS_SMODE    = 4'h4;  // Slave mode
    localparam logic [3:0] OFS_MDATA    = 4'h5;  // Master delay data
    localparam logic [3:0] OFS_SCAP     = 4'h6;  // Slave capture data
    localparam logic [3:0] OFS_MCNT     = 4'h7;  // Master down counter
    localparam logic [3:0] OFS_SCNT     = 4'h8;  // Slave up counter
    localparam logic [3:0] OFS_OUTCFG   = 4'h9;  // Output mode/level/enable/bit
    localparam logic [3:0] OFS_PORT     = 4'hA;  // Port register and port mode
    localparam logic [3:0] OFS_START    = 4'hB;  // Start trigger (write), enable status (read)
    localparam logic [3:0] OFS_STOP     = 4'hC;  // Stop trigger
    localparam logic [3:0] OFS_SSTAT    = 4'hD;  // Slave status
    localparam logic [3:0] OFS_IRQST    = 4'hE;  // Interrupt status, read clears
    localparam logic [3:0] OFS_IRQMSK   = 4'hF;  // Interrupt mask

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OC_MOM  = 0;  // Master output mode bit
    localparam int OC_SOM  = 1;  // Slave output mode bit
    localparam int OC_MOL  = 2;  // Master output level
    localparam int OC_SOL  = 3;  // Slave output level (polarity)
    localparam int OC_MOE  = 4;  // Master output enable
    localparam int OC_SOE  = 5;  // Slave output enable
    localparam int OC_SOUT = 6;  // Slave output bit
    localparam int PT_PORT = 0;  // Port latch
    localparam int PT_PM   = 1;  // Port mode, 1 = input
    localparam int MD_EDGE = 0;  // Detection edge, 0 rising 1 falling
    localparam int MD_CKS  = 1;  // Operating clock b select
    localparam int PS_A_LO = 0;  // Prescaler a field
    localparam int PS_B_LO = 4;  // Prescaler b field
    localparam int PS_W    = 4;

    // Reset values and counter constants
    localparam logic [6:0] OUTCFG_RST = 7'h00;
    localparam logic [1:0] PORT_RST   = 2'h3;   // Input mode, latch high
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_FULL  = 16'hFFFF;
    localparam logic [15:0] TRIG_ADJ  = 16'h0001; // Load plus edge latency gives +2

    typedef enum logic [1:0] {
        TOPS_IRQ_MASTER = 2'h0,
        TOPS_IRQ_SLAVE  = 2'h1
    } tops_irq_t;
endpackage : tops_pkg

// [rtl/tops_prescaler_if.sv]
// Purpose: Prescaler to channel strobes.
// Assumes: One clock domain.
// Notes:   Ticks are single-cycle strobes.
interface tops_prescaler_if;
    logic [3:0] sel_a;   // Divider exponent for clock a
    logic [3:0] sel_b;   // Divider exponent for clock b
    logic       run;     // Unit powered
    logic       tick_a;  // Operating clock a strobe
    logic       tick_b;  // Operating clock b strobe
    modport ctl (output sel_a, output sel_b, output run, input tick_a, input tick_b);
    modport div (input sel_a, input sel_b, input run, output tick_a, output tick_b);
endinterface : tops_prescaler_if

// [rtl/tops_prescaler.sv]
// Purpose: Power-of-two operating clock strobes.
// Assumes: Stopped while unit power is off.
// Notes:   Exponent 0 gives a strobe every cycle.
module tops_prescaler (
    input  wire logic     clk,      // System clock
    input  wire logic     sys_rst,  // Synchronous reset
    tops_prescaler_if.div pif       // Select and strobe group
);
    logic [15:0] div_q;

    // ------------------------------------------------------------
    // Free divider, held at zero while the clock supply is off
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || !pif.run) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    function automatic logic tick_of(input logic [15:0] c, input logic [3:0] s);
        logic [15:0] m;
        m = (16'h0001 << s) - 16'h0001;
        return ((c & m) == m);
    endfunction

    // Strobes only while powered
    assign pif.tick_a = pif.run && tick_of(div_q, pif.sel_a);
    assign pif.tick_b = pif.run && tick_of(div_q, pif.sel_b);
endmodule : tops_prescaler

// [rtl/tops_oneshot.sv]
// Purpose: Two-input one-shot pulse timer: delayed start, captured end.
// Assumes: Pins synchronous to clk.
// Notes:   One master/slave pair per instance.
//
// Added by the designer: the register addresses and the address-and-strobe port.

// How it works
// - Unit off at reset; access to all but the power register refused while power is 0.
// - Power set first; clock runs, writes taken, channels stopped.
// - Master output mode bit is 0.
// - Slave output mode bit is 1; master events govern it.
// - Master level and enable 0; pin Hi-Z in input mode.
// - While stopped, output bit edits set the latch, which reaches the pin when slave output is enabled.
// - Port output mode drives pin at output bit level (when slave output is enabled) ORed with the port latch.
// - Master is channel 0 or 2; slave is channel 3.
// - Delay is master data plus two count periods.
// - Master at zero interrupts, drives active, stops.
// - End edge captures, clears slave count, interrupts, drives inactive.
// - Capture sets overflow flag on counter overflow, else clears.
module tops_oneshot #(
    parameter int MASTER_CH = 0,    // Master channel number
    parameter int SLAVE_CH  = 3,    // Slave channel number
    parameter int CNT_W     = 16    // Counter width
) (
    input  wire logic        clk,          // 125 MHz system clock
    input  wire logic        sys_rst,      // Synchronous reset, high
    input  wire logic [3:0]  reg_addr,     // Register word index
    input  wire logic [15:0] reg_wdata,    // Write data
    input  wire logic        reg_wr,       // Write strobe
    input  wire logic        reg_rd,       // Read strobe
    output logic      [15:0] reg_rdata,    // Read data, cycle after strobe
    input  wire logic        start_trig_in,// Start trigger pin
    input  wire logic        end_trig_in,  // End trigger pin
    output logic             pulse_out,    // Pulse pin output
    output logic             pulse_oe,     // Pulse pin output enable
    output logic             irq           // Level interrupt
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (!(MASTER_CH == 0 || MASTER_CH == 2) || SLAVE_CH != 3) begin
            $error("master must be channel 0 or 2 and slave channel 3");
        end
        if (CNT_W != 16) begin
            $error("counter width must be 16");
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic        pwr_q;
    logic [7:0]  presc_q;
    logic [1:0]  nfen_q;
    logic [1:0]  mmode_q;
    logic [1:0]  smode_q;
    logic [15:0] mdata_q;
    logic [15:0] scap_q;
    logic [15:0] mcnt_q;
    logic [15:0] scnt_q;
    logic [6:0]  outcfg_q;
    logic [1:0]  port_q;
    logic        en_q;          // Channel pair enable status
    logic        mwait_q;       // Master idle, awaiting start trigger
    logic        mrun_q;        // Master counting down
    logic        sactive_q;     // Slave measuring active period
    logic [1:0]  ovcnt_q;       // Full-count periods this active period
    logic        ovf_q;
    logic [1:0]  irqst_q;
    logic [1:0]  irqmsk_q;
    logic        tout_q;        // Timer output latch
    logic        st_s_q, en_s_q;// Filtered trigger samples
    logic        st_p_q, en_p_q;// Previous samples for edges
    logic [15:0] rdata_q;

    tops_prescaler_if pif();

    tops_prescaler u_presc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pif     (pif)
    );

    assign pif.sel_a = presc_q[tops_pkg::PS_A_LO +: tops_pkg::PS_W];
    assign pif.sel_b = presc_q[tops_pkg::PS_B_LO +: tops_pkg::PS_W];
    assign pif.run   = pwr_q;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = reg_wr && (pwr_q || reg_addr == tops_pkg::OFS_PWR);
    assign rd_ok = reg_rd && (pwr_q || reg_addr == tops_pkg::OFS_PWR);

    function automatic logic wr_at(input logic ok, input logic [3:0] a,
                                   input logic [3:0] ofs);
        return ok && (a == ofs);
    endfunction

    logic start_sw;
    logic stop_sw;
    assign start_sw = wr_at(wr_ok, reg_addr, tops_pkg::OFS_START) && reg_wdata[0];
    assign stop_sw  = wr_at(wr_ok, reg_addr, tops_pkg::OFS_STOP) && reg_wdata[0];

    // Count clock per channel from its mode clock select
    logic mtick;
    logic stick;
    assign mtick = mmode_q[tops_pkg::MD_CKS] ? pif.tick_b : pif.tick_a;
    assign stick = smode_q[tops_pkg::MD_CKS] ? pif.tick_b : pif.tick_a;

    // ------------------------------------------------------------
    // Power enable
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_q <= 1'b0;
        end else if (wr_at(reg_wr, reg_addr, tops_pkg::OFS_PWR)) begin
            pwr_q <= reg_wdata[0];
        end
    end

    logic unit_clr;
    assign unit_clr = sys_rst || !pwr_q;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (unit_clr) begin
            presc_q  <= 8'h00;
            nfen_q   <= 2'h0;
            mmode_q  <= 2'h0;
            smode_q  <= 2'h0;
            mdata_q  <= tops_pkg::CNT_ZERO;
            outcfg_q <= tops_pkg::OUTCFG_RST;
            port_q   <= tops_pkg::PORT_RST;
            irqmsk_q <= 2'h0;
        end else begin
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_PRESC)) begin
                presc_q <= reg_wdata[7:0];
            end
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_NFEN)) begin
                nfen_q <= reg_wdata[1:0];
            end
            // Only edge select may change during operation
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_MMODE)) begin
                mmode_q[tops_pkg::MD_EDGE] <= reg_wdata[tops_pkg::MD_EDGE];
                if (!en_q) begin
                    mmode_q[tops_pkg::MD_CKS] <= reg_wdata[tops_pkg::MD_CKS];
                end
            end
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_SMODE)) begin
                smode_q[tops_pkg::MD_EDGE] <= reg_wdata[tops_pkg::MD_EDGE];
                if (!en_q) begin
                    smode_q[tops_pkg::MD_CKS] <= reg_wdata[tops_pkg::MD_CKS];
                end
            end
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_MDATA) && !en_q) begin
                mdata_q <= reg_wdata;
            end
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_OUTCFG) && !en_q) begin
                outcfg_q <= reg_wdata[6:0];
            end
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_PORT)) begin
                port_q <= reg_wdata[1:0];
            end
            if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_IRQMSK)) begin
                irqmsk_q <= reg_wdata[1:0];
            end
        end
    end

    // Pair valid with master mode 0, slave mode 1
    logic pair_ok;
    assign pair_ok = !outcfg_q[tops_pkg::OC_MOM] && outcfg_q[tops_pkg::OC_SOM];

    // ------------------------------------------------------------
    // Trigger sampling
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (unit_clr) begin
            st_s_q <= 1'b0;
            en_s_q <= 1'b0;
            st_p_q <= 1'b0;
            en_p_q <= 1'b0;
        end else begin
            // Filter on: sample once per count clock; off: every cycle
            if (mtick || !nfen_q[0]) begin
                st_s_q <= start_trig_in;
                st_p_q <= st_s_q;
            end
            if (stick || !nfen_q[1]) begin
                en_s_q <= end_trig_in;
                en_p_q <= en_s_q;
            end
        end
    end

    function automatic logic edge_of(input logic cur, input logic prv, input logic fall);
        return fall ? (prv && !cur) : (cur && !prv);
    endfunction

    logic start_edge;
    logic end_edge;
    assign start_edge = edge_of(st_s_q, st_p_q, mmode_q[tops_pkg::MD_EDGE])
                        && (mtick || !nfen_q[0]);
    assign end_edge   = edge_of(en_s_q, en_p_q, smode_q[tops_pkg::MD_EDGE])
                        && (stick || !nfen_q[1]);

    // ------------------------------------------------------------
    // Channel enable status
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (unit_clr) begin
            en_q <= 1'b0;
        end else if (stop_sw) begin
            en_q <= 1'b0;
        end else if (start_sw) begin
            en_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Master one-count down counter
    // ------------------------------------------------------------
    logic mdone;
    assign mdone = en_q && mrun_q && mtick && (mcnt_q == tops_pkg::CNT_ZERO);

    always_ff @(posedge clk) begin
        if (unit_clr) begin
            mcnt_q  <= tops_pkg::CNT_ZERO;
            mrun_q  <= 1'b0;
            mwait_q <= 1'b0;
        end else if (!en_q) begin
            mrun_q  <= 1'b0; // Counter holds its value when stopped
            mwait_q <= start_sw;
        end else if ((mwait_q || !mrun_q) && (start_edge || start_sw)) begin
            // Load; first count clock after load is the extra period
            mcnt_q  <= mdata_q + tops_pkg::TRIG_ADJ;
            mrun_q  <= 1'b1;
            mwait_q <= 1'b0;
        end else if (mdone) begin
            mcnt_q <= tops_pkg::CNT_FULL;
            mrun_q <= 1'b0;
        end else if (mrun_q && mtick) begin
            mcnt_q <= mcnt_q - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Slave capture up counter and overflow tracking
    // ------------------------------------------------------------
    logic scap_ev;
    assign scap_ev = en_q && sactive_q && end_edge;

    always_ff @(posedge clk) begin
        if (unit_clr) begin
            scnt_q    <= tops_pkg::CNT_ZERO;
            scap_q    <= tops_pkg::CNT_ZERO;
            sactive_q <= 1'b0;
            ovcnt_q   <= 2'h0;
            ovf_q     <= 1'b0;
        end else if (en_q) begin
            if (mdone) begin
                scnt_q    <= tops_pkg::CNT_ZERO; // Master event restarts width
                sactive_q <= 1'b1;
                ovcnt_q   <= 2'h0;
            end else if (scap_ev) begin
                scap_q    <= scnt_q;
                scnt_q    <= tops_pkg::CNT_ZERO;
                sactive_q <= 1'b0;
                ovf_q     <= (ovcnt_q != 2'h0);
            end else if (sactive_q && stick) begin
                scnt_q <= scnt_q + 16'h0001;
                if (scnt_q == tops_pkg::CNT_FULL && ovcnt_q != 2'h3) begin
                    ovcnt_q <= ovcnt_q + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Timer output latch; only hardware events move it while running
    // ------------------------------------------------------------
    logic act_lvl;
    assign act_lvl = !outcfg_q[tops_pkg::OC_SOL]; // Polarity 1 gives active low

    always_ff @(posedge clk) begin
        if (unit_clr) begin
            tout_q <= 1'b0;
        end else if (en_q && pair_ok && outcfg_q[tops_pkg::OC_SOE]) begin
            if (mdone) begin
                tout_q <= act_lvl;
            end else if (scap_ev) begin
                tout_q <= !act_lvl;
            end
        end else if (wr_at(wr_ok, reg_addr, tops_pkg::OFS_OUTCFG) && !en_q) begin
            tout_q <= reg_wdata[tops_pkg::OC_SOUT]; // Output bit sets the latch
        end
    end

    // ------------------------------------------------------------
    // Pin drive follows port mode
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (unit_clr) begin
            pulse_oe  <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            pulse_oe <= !port_q[tops_pkg::PT_PM];
            // Output bit edits while stopped reach the pin through the latch when slave output is enabled
            if (!port_q[tops_pkg::PT_PM]) begin
                pulse_out <= (outcfg_q[tops_pkg::OC_SOE] ? tout_q : 1'b0)
                             | port_q[tops_pkg::PT_PORT];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over read clear
    // ------------------------------------------------------------
    logic [1:0] irq_set;
    assign irq_set = {scap_ev, mdone};

    always_ff @(posedge clk) begin
        if (unit_clr) begin
            irqst_q <= 2'h0;
        end else if (rd_ok && reg_addr == tops_pkg::OFS_IRQST) begin
            irqst_q <= irq_set;
        end else begin
            irqst_q <= irqst_q | irq_set;
        end
    end

    always_ff @(posedge clk) begin
        if (unit_clr) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irqst_q | irq_set) & irqmsk_q);
        end
    end

    // ------------------------------------------------------------
    // Read mux; refused and idle reads return zero
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (!rd_ok) begin
            rdata_q <= 16'h0000;
        end else begin
            unique case (reg_addr)
                tops_pkg::OFS_PWR:    rdata_q <= {15'h0000, pwr_q};
                tops_pkg::OFS_PRESC:  rdata_q <= {8'h00, presc_q};
                tops_pkg::OFS_NFEN:   rdata_q <= {14'h0000, nfen_q};
                tops_pkg::OFS_MMODE:  rdata_q <= {14'h0000, mmode_q};
                tops_pkg::OFS_SMODE:  rdata_q <= {14'h0000, smode_q};
                tops_pkg::OFS_MDATA:  rdata_q <= mdata_q;
                tops_pkg::OFS_SCAP:   rdata_q <= scap_q;
                tops_pkg::OFS_MCNT:   rdata_q <= mcnt_q;
                tops_pkg::OFS_SCNT:   rdata_q <= scnt_q;
                tops_pkg::OFS_OUTCFG: rdata_q <= {8'h00, tout_q, outcfg_q[6:0]};
                tops_pkg::OFS_PORT:   rdata_q <= {14'h0000, port_q};
                tops_pkg::OFS_START:  rdata_q <= {15'h0000, en_q};
                tops_pkg::OFS_STOP:   rdata_q <= 16'h0000;
                tops_pkg::OFS_SSTAT:  rdata_q <= {15'h0000, ovf_q};
                tops_pkg::OFS_IRQST:  rdata_q <= {14'h0000, irqst_q};
                tops_pkg::OFS_IRQMSK: rdata_q <= {14'h0000, irqmsk_q};
            endcase
        end
    end

    assign reg_rdata = rdata_q;
endmodule : tops_oneshot

// [test/tops_chk.sv]
// Purpose: Port checks for the one-shot pulse timer.
// Assumes: Only top ports are seen.
// Notes:   Mirrors power and port mode.
module tops_chk (
    input wire logic        clk,       // Clock
    input wire logic        sys_rst,   // Reset
    input wire logic [3:0]  reg_addr,  // Address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic        reg_wr,    // Write strobe
    input wire logic        reg_rd,    // Read strobe
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic        pulse_out, // Pin level
    input wire logic        pulse_oe,  // Pin enable
    input wire logic        irq        // Interrupt
);
    logic pwr_q; // Mirrored power bit
    logic pm_q;  // Mirrored port mode, 1 = input
    // Power-off returns port mode to input like reset does
    always_ff @(posedge clk) begin
        if (sys_rst || (reg_wr && reg_addr == tops_pkg::OFS_PWR && !reg_wdata[0])) begin
            pwr_q <= 1'b0;
            pm_q  <= 1'b1;
        end else if (reg_wr && reg_addr == tops_pkg::OFS_PWR) begin
            pwr_q <= 1'b1;
        end else if (reg_wr && pwr_q && reg_addr == tops_pkg::OFS_PORT) begin
            pm_q <= reg_wdata[tops_pkg::PT_PM];
        end
    end
    // ----
    // Assertions
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("bad idle data");
    off_read_zero_a: assert property (reg_rd && !pwr_q && reg_addr != tops_pkg::OFS_PWR
        |=> reg_rdata == 16'h0000) else $error("off read");
    pwr_readback_a: assert property (reg_rd && reg_addr == tops_pkg::OFS_PWR
        |=> reg_rdata == {15'h0000, $past(pwr_q)}) else $error("bad power");
    off_no_drive_a: assert property (!pwr_q && !$past(pwr_q) && !$past(pwr_q, 2)
        |-> !pulse_oe && !pulse_out) else $error("off drive");
    off_irq_low_a: assert property (!pwr_q && !$past(pwr_q) && !$past(pwr_q, 2)
        |-> !irq) else $error("off irq");
    pwr_off_clear_a: assert property (reg_wr && reg_addr == tops_pkg::OFS_PWR && !reg_wdata[0]
        |=> ##1 !irq && !pulse_oe) else $error("off clear");
    input_hiz_a: assert property (pm_q && $past(pm_q) |-> !pulse_oe)
        else $error("input drive");
    output_drive_a: assert property (pwr_q && $past(pwr_q) && !pm_q && !$past(pm_q)
        |-> pulse_oe) else $error("no drive");
    oe_cause_a: assert property ($changed(pulse_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("oe cause");
    cover property (pwr_q && $rose(pulse_out));
    cover property (pwr_q && $fell(pulse_out));
    cover property ($rose(irq));
endmodule // tops_chk
bind tops_oneshot tops_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pulse_out(pulse_out), .pulse_oe(pulse_oe), .irq(irq));

// [test/tops_pin_model.sv]
// Purpose: Trigger sources and pulse pin load.
// Assumes: Requests are one-cycle pulses.
// Notes:   Pull-up holds an undriven pin high.
module tops_pin_model (
    input  wire logic clk,           // Clock
    input  wire logic start_req,     // Ask for a start edge
    input  wire logic end_req,       // Ask for an end edge
    input  wire logic pulse_out,     // Pin level from block
    input  wire logic pulse_oe,      // Pin enable from block
    output logic      start_trig_in, // Start pin
    output logic      end_trig_in,   // End pin
    output logic      pin_level      // Resolved pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] st_q = 3'h0; // Start pin high time
    logic [2:0] en_q = 3'h0; // End pin high time
    // Four-cycle pulses give clean edges
    always_ff @(posedge clk) begin
        st_q <= start_req ? 3'h4 : st_q - {2'h0, st_q != 3'h0};
        en_q <= end_req ? 3'h4 : en_q - {2'h0, en_q != 3'h0};
    end
    assign start_trig_in = st_q != 3'h0;
    assign end_trig_in   = en_q != 3'h0;
    assign pin_level     = pulse_oe ? pulse_out : 1'b1;
endmodule // tops_pin_model

// [test/tb.sv]
// Purpose: Self-checking bench for the one-shot pulse timer.
// Assumes: 125 MHz clock, prescaler at every-cycle rate.
// Notes:   Second shot runs past a full counter wrap.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] DLY = 16'h0005; // Master delay data
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic start_req = 1'b0, end_req = 1'b0, st_pin, en_pin, p_out, p_oe, irq, pin;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, last_rd;
    int error_cnt = 0, checks_done = 0, n, cyc = 0, t0;
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    tops_oneshot uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start_trig_in(st_pin), .end_trig_in(en_pin), .pulse_out(p_out),
        .pulse_oe(p_oe), .irq(irq));
    tops_pin_model u_pin (.clk(clk), .start_req(start_req), .end_req(end_req),
        .pulse_out(p_out), .pulse_oe(p_oe), .start_trig_in(st_pin),
        .end_trig_in(en_pin), .pin_level(pin));
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Empty name reads without comparing
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        last_rd = reg_rdata;
        if (what != "") chk(what, reg_rdata, exp);
    endtask
    // Bounded irq wait
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 200) begin
            @(negedge clk);
            c++;
        end
        if (c >= 200) begin
            chk("irq wait", 16'h0000, 16'h0001);
            finish_test();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        wr(tops_pkg::OFS_MDATA, 16'h1234);
        rd(tops_pkg::OFS_MDATA, 16'h0000, "mdata off");
        wr(tops_pkg::OFS_PWR, 16'h0001);
        rd(tops_pkg::OFS_PWR, 16'h0001, "power");
        rd(tops_pkg::OFS_MDATA, 16'h0000, "mdata kept");
        rd(tops_pkg::OFS_START, 16'h0000, "stopped");
        wr(tops_pkg::OFS_PRESC, 16'h0000);
        wr(tops_pkg::OFS_NFEN, 16'h0000);
        wr(tops_pkg::OFS_MMODE, 16'h0000);
        wr(tops_pkg::OFS_SMODE, 16'h0000);
        wr(tops_pkg::OFS_MDATA, DLY);
        wr(tops_pkg::OFS_OUTCFG, 16'h0062);
        chk("oe input mode", {15'h0000, p_oe}, 16'h0000);
        wr(tops_pkg::OFS_OUTCFG, 16'h0022);
        rd(tops_pkg::OFS_OUTCFG, 16'h0022, "outcfg");
        wr(tops_pkg::OFS_IRQMSK, 16'h0003);
        wr(tops_pkg::OFS_PORT, 16'h0000);
        repeat (2) @(negedge clk);
        chk("pin drive", {14'h0000, p_oe, pin}, 16'h0002);
        wr(tops_pkg::OFS_START, 16'h0001);
        // Short shot, then a wrapping one
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            start_req <= 1'b1;
            @(posedge clk);
            start_req <= 1'b0;
            wait_irq(n);
            t0 = cyc;
            chk("delay", 16'((n >= DLY + 2) && (n <= DLY + 6)), 16'h0001);
            @(negedge clk);
            chk("pulse active", {15'h0000, pin}, 16'h0001);
            rd(tops_pkg::OFS_IRQST, 16'h0001, "master irq");
            repeat (k == 0 ? 40 : 66000) @(posedge clk);
            end_req <= 1'b1;
            @(posedge clk);
            end_req <= 1'b0;
            wait_irq(n);
            t0 = cyc - t0 - 1;
            @(negedge clk);
            chk("pulse ended", {15'h0000, pin}, 16'h0000);
            rd(tops_pkg::OFS_IRQST, 16'h0002, "slave irq");
            rd(tops_pkg::OFS_SCAP, 16'h0000, "");
            if (k == 0) chk("capture", 16'(int'(last_rd) >= t0 - 3 && int'(last_rd) <= t0 + 3), 16'h0001);
            rd(tops_pkg::OFS_SSTAT, 16'(k), "overflow");
        end
        wr(tops_pkg::OFS_PWR, 16'h0000);
        wr(tops_pkg::OFS_PWR, 16'h0001);
        rd(tops_pkg::OFS_OUTCFG, 16'h0000, "outcfg cleared");
        chk("pin released", {15'h0000, p_oe}, 16'h0000);
        finish_test();
    end
endmodule // tb
